//--- hdl/laser_cfg_pkg.sv
// constants, field layouts and carrier types of the laser driver configuration bank
// assumes a single 25 MHz clock and a serial write port of 3 address plus 8 data bits
// Behaviour
// - laser output only while enable bit is 1; clearing it clears a latched fault
// - polarity bit: 1 cathode to supply, 0 anode to ground
// - range bit: 1 high range 2.5 uA steps, 0 low range 0.5 uA steps
// - open-loop bit: 1 direct bias control, 0 closed-loop power control
// - fault detection enable bit: 1 on, 0 off
// - modulation range bit: 1 gives 0-40 mA, 0 gives 0-20 mA
// - equalizer bit inverted: 1 disables equalizer, 0 enables it
// - wide modulation range: 156 uA per code step
// - narrow modulation range: 78 uA per code step
// - bias code fills all eight bits at address 2, bit 7 most significant
// - equalizer code fills all eight bits at address 3, bit 7 most significant
// - closed loop low range: 0.5 uA times ratio times code, at most 20 mA
// - closed loop high range: 2.5 uA times ratio times code, at most 20 mA
// - open loop: bias equals 75 uA times the bias code
// - disabled equalizer is bypassed, adjustment code has no effect
// - enabled equalizer: code zero is strongest, higher codes weaker
// - enabled equalizer: code all ones is weakest
// - reset clears every configuration register to zero
// - on stop, received data goes to the register the address selects
// - open-loop bit at bit 4, equalizer disable bit at bit 1
// - enabled fault zeroes bias and modulation codes and latches fault output

package laser_cfg_pkg;

    localparam int ADDR_W     = 3;
    localparam int DATA_W     = 8;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam int CUR_W      = 26;

    // register addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_MOD  = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_BIAS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_EQ   = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 3'h3;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // control register fields
    localparam int EN_BIT   = 7;
    localparam int POL_BIT  = 6;
    localparam int RNG_BIT  = 5;
    localparam int OPEN_BIT = 4;
    localparam int FDET_BIT = 3;
    localparam int MRNG_BIT = 2;
    localparam int EQD_BIT  = 1;

    // current scaling, nanoamps
    localparam int COUPLING_RATIO = 30;
    localparam int PD_STEP_LO_NA  = 500;
    localparam int PD_STEP_HI_NA  = 2500;
    localparam int OPEN_STEP_NA   = 75000;
    localparam int MOD_STEP_HI_NA = 156000;
    localparam int MOD_STEP_LO_NA = 78000;
    localparam logic [CUR_W-1:0] BIAS_LIMIT_NA = 26'd20000000;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] modCode;
        logic [DATA_W-1:0] biasCode;
        logic [DATA_W-1:0] equalizer_adjust_code;
    } cfg_regs_s;

    typedef struct packed {
        logic              stb;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_req_s;

    typedef struct packed {
        logic              laserEnable;
        logic              faultOutput;
        logic              monitorPolarity;
        logic              monitorRangeHigh;
        logic              openLoop;
        logic              faultDetectOn;
        logic              modRangeHigh;
        logic              eqBypass;
        logic [DATA_W-1:0] modCode;
        logic [DATA_W-1:0] biasCode;
        logic [DATA_W-1:0] eqStrength;
        logic [CUR_W-1:0]  modCurrentNa;
        logic [CUR_W-1:0]  biasCurrentNa;
    } drive_s;

endpackage : laser_cfg_pkg

//--- hdl/laser_driver_control_registers.sv
// configuration bank of the laser driver and the codes it hands to the DACs
// assumes fault and disable levels come from analog/pin domains and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module laser_driver_control_registers #(
    parameter int COUPLING_RATIO = laser_cfg_pkg::COUPLING_RATIO
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // serial write port
    input  wire logic                  sck,
    input  wire logic                  sda,
    // laser safety inputs
    input  wire logic                  disablePin,
    input  wire logic                  faultDetected,
    // drive to DACs, equalizer and fault pin
    output laser_cfg_pkg::drive_s      drive
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        laser_cfg_pkg::cfg_regs_s regs;
        logic [1:0]               disableSync;
        logic [1:0]               faultSync;
        logic                     faultLatched;
        laser_cfg_pkg::drive_s    drv;
    } ctl_state_s;

    ctl_state_s             st_q;
    ctl_state_s             st_d;
    laser_cfg_pkg::wr_req_s wrReq;

    two_wire_rx u_rx (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .sck     (sck),
        .sda     (sda),
        .wrReq   (wrReq)
    );

    ////////////////////////////////////////////////////////////////////////////////

    logic              enableBit;
    logic              disableActive;
    logic              chipOn;
    logic [laser_cfg_pkg::DATA_W-1:0] biasEff;
    logic [laser_cfg_pkg::DATA_W-1:0] modEff;
    logic [laser_cfg_pkg::CUR_W-1:0]  biasStep;
    logic [laser_cfg_pkg::CUR_W-1:0]  modStep;
    logic [laser_cfg_pkg::CUR_W-1:0]  biasRaw;

    assign enableBit     = st_q.regs.ctrl[laser_cfg_pkg::EN_BIT];
    assign disableActive = st_q.disableSync[1];
    assign chipOn        = enableBit && !disableActive;

    // a latched fault forces both current codes to zero
    assign biasEff = st_q.faultLatched ? '0 : st_q.regs.biasCode;
    assign modEff  = st_q.faultLatched ? '0 : st_q.regs.modCode;

    always_comb begin
        if (st_q.regs.ctrl[laser_cfg_pkg::OPEN_BIT]) begin
            biasStep = laser_cfg_pkg::CUR_W'(laser_cfg_pkg::OPEN_STEP_NA);
        end else if (st_q.regs.ctrl[laser_cfg_pkg::RNG_BIT]) begin
            biasStep = laser_cfg_pkg::CUR_W'(laser_cfg_pkg::PD_STEP_HI_NA * COUPLING_RATIO);
        end else begin
            biasStep = laser_cfg_pkg::CUR_W'(laser_cfg_pkg::PD_STEP_LO_NA * COUPLING_RATIO);
        end
        if (st_q.regs.ctrl[laser_cfg_pkg::MRNG_BIT]) begin
            modStep = laser_cfg_pkg::CUR_W'(laser_cfg_pkg::MOD_STEP_HI_NA);
        end else begin
            modStep = laser_cfg_pkg::CUR_W'(laser_cfg_pkg::MOD_STEP_LO_NA);
        end
    end

    assign biasRaw = laser_cfg_pkg::CUR_W'(biasStep * biasEff);

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_d         = st_q;
        st_d.disableSync = {st_q.disableSync[0], disablePin};
        st_d.faultSync   = {st_q.faultSync[0], faultDetected};

        // writes beyond the last implemented address fall through untouched
        if (wrReq.stb && wrReq.addr <= laser_cfg_pkg::ADDR_LAST) begin
            unique case (wrReq.addr)
                laser_cfg_pkg::ADDR_CTRL: st_d.regs.ctrl     = wrReq.data;
                laser_cfg_pkg::ADDR_MOD:  st_d.regs.modCode  = wrReq.data;
                laser_cfg_pkg::ADDR_BIAS: st_d.regs.biasCode = wrReq.data;
                default:                  st_d.regs.equalizer_adjust_code    = wrReq.data;
            endcase
        end

        // disabling clears the latch; a fault still present sets it again once re-enabled
        if (!chipOn) begin
            st_d.faultLatched = 1'b0;
        end else if (st_q.regs.ctrl[laser_cfg_pkg::FDET_BIT] && st_q.faultSync[1]) begin
            st_d.faultLatched = 1'b1;
        end

        st_d.drv.laserEnable      = chipOn && !st_q.faultLatched;
        st_d.drv.faultOutput      = st_q.faultLatched;
        st_d.drv.monitorPolarity  = st_q.regs.ctrl[laser_cfg_pkg::POL_BIT];
        st_d.drv.monitorRangeHigh = st_q.regs.ctrl[laser_cfg_pkg::RNG_BIT];
        st_d.drv.openLoop         = st_q.regs.ctrl[laser_cfg_pkg::OPEN_BIT];
        st_d.drv.faultDetectOn    = st_q.regs.ctrl[laser_cfg_pkg::FDET_BIT];
        st_d.drv.modRangeHigh     = st_q.regs.ctrl[laser_cfg_pkg::MRNG_BIT];
        st_d.drv.eqBypass         = st_q.regs.ctrl[laser_cfg_pkg::EQD_BIT];
        st_d.drv.modCode          = modEff;
        st_d.drv.biasCode         = biasEff;
        // strength rises as the code falls; bypass leaves the code without effect
        st_d.drv.eqStrength       = st_q.regs.ctrl[laser_cfg_pkg::EQD_BIT]
                                    ? '0 : ~st_q.regs.equalizer_adjust_code;
        st_d.drv.modCurrentNa     = laser_cfg_pkg::CUR_W'(modStep * modEff);
        if (!st_q.regs.ctrl[laser_cfg_pkg::OPEN_BIT] && biasRaw > laser_cfg_pkg::BIAS_LIMIT_NA) begin
            st_d.drv.biasCurrentNa = laser_cfg_pkg::BIAS_LIMIT_NA;
        end else begin
            st_d.drv.biasCurrentNa = biasRaw;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q           <= '0;
            st_q.regs.ctrl <= laser_cfg_pkg::REG_RESET;
            st_q.regs.modCode  <= laser_cfg_pkg::REG_RESET;
            st_q.regs.biasCode <= laser_cfg_pkg::REG_RESET;
            st_q.regs.equalizer_adjust_code    <= laser_cfg_pkg::REG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign drive = st_q.drv;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_reset_clear;
        @(posedge mclk) disable iff (1'b0)
        sys_rst |=> (st_q.regs == '0);
    endproperty
    a_reset_clears_regs: assert property (p_reset_clear)
        else $error("registers not cleared by reset");

    a_write_bias_lands: assert property (
        wrReq.stb && wrReq.addr == laser_cfg_pkg::ADDR_BIAS
        |=> st_q.regs.biasCode == $past(wrReq.data))
        else $error("bias write not stored");

    a_write_eq_lands: assert property (
        wrReq.stb && wrReq.addr == laser_cfg_pkg::ADDR_EQ
        |=> st_q.regs.equalizer_adjust_code == $past(wrReq.data)
            ##1 (drive.eqBypass || drive.eqStrength == ~st_q.regs.equalizer_adjust_code))
        else $error("equalizer write not stored or mapped");

    a_high_addr_ignored: assert property (
        wrReq.stb && wrReq.addr > laser_cfg_pkg::ADDR_LAST |=> $stable(st_q.regs))
        else $error("write above last address changed a register");

    a_regs_hold_idle: assert property (
        !wrReq.stb |=> $stable(st_q.regs))
        else $error("register changed without a write");

    a_fault_zeroes_codes: assert property (
        drive.faultOutput |-> drive.biasCode == '0 && drive.modCode == '0
                              && !drive.laserEnable)
        else $error("fault output without zeroed codes");

    a_enable_clears_fault: assert property (
        !enableBit |=> !st_q.faultLatched && !drive.laserEnable ##1 !drive.faultOutput)
        else $error("fault or enable kept while enable bit low");

    a_fault_needs_enable: assert property (
        !st_q.regs.ctrl[laser_cfg_pkg::FDET_BIT] && !st_q.faultLatched |=> !st_q.faultLatched)
        else $error("fault latched with detection off");

    a_eq_bypass_mute: assert property (
        drive.eqBypass |-> drive.eqStrength == '0)
        else $error("equalizer strength nonzero while bypassed");

    a_mod_step_size: assert property (
        $stable(st_q.regs) && $stable(st_q.faultLatched)
        |=> drive.modCurrentNa == laser_cfg_pkg::CUR_W'(drive.modCode *
            (drive.modRangeHigh ? laser_cfg_pkg::MOD_STEP_HI_NA : laser_cfg_pkg::MOD_STEP_LO_NA)))
        else $error("modulation current scaling wrong");

    a_open_loop_bias: assert property (
        $stable(st_q.regs) && $stable(st_q.faultLatched) && drive.openLoop
        |=> drive.biasCurrentNa == laser_cfg_pkg::CUR_W'(drive.biasCode * laser_cfg_pkg::OPEN_STEP_NA))
        else $error("open loop bias scaling wrong");

    a_bias_limit: assert property (
        !drive.openLoop |-> drive.biasCurrentNa <= laser_cfg_pkg::BIAS_LIMIT_NA)
        else $error("closed loop setpoint above limit");

    c_ctrl_write:  cover property (wrReq.stb && wrReq.addr == laser_cfg_pkg::ADDR_CTRL);
    c_fault_latch: cover property ($rose(drive.faultOutput));
    c_eq_active:   cover property (!drive.eqBypass && drive.eqStrength != '0);
    c_laser_on:    cover property (drive.laserEnable && drive.modCode != '0);

endmodule : laser_driver_control_registers

`default_nettype wire

//--- hdl/two_wire_rx.sv
// serial write receiver: start, 3 address bits, 8 data bits, stop
// assumes sck and sda arrive from pins asynchronous to mclk, slow against 40 ns
`timescale 1ns/1ps
`default_nettype none

module two_wire_rx (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // serial pins
    input  wire logic                  sck,
    input  wire logic                  sda,
    // completed write, one-cycle strobe
    output laser_cfg_pkg::wr_req_s     wrReq
);

    typedef struct packed {
        logic [1:0]                           sckSync;
        logic [1:0]                           sdaSync;
        logic                                 sckPrev;
        logic                                 sdaPrev;
        logic                                 active;
        logic [3:0]                           bitCnt;
        logic [laser_cfg_pkg::FRAME_BITS-1:0] shift;
        laser_cfg_pkg::wr_req_s               req;
    } rx_state_s;

    rx_state_s st_q;
    rx_state_s st_d;
    logic      sckNow;
    logic      sdaNow;

    assign sckNow = st_q.sckSync[1];
    assign sdaNow = st_q.sdaSync[1];

    always_comb begin
        st_d            = st_q;
        st_d.sckSync    = {st_q.sckSync[0], sck};
        st_d.sdaSync    = {st_q.sdaSync[0], sda};
        st_d.sckPrev    = sckNow;
        st_d.sdaPrev    = sdaNow;
        st_d.req.stb    = 1'b0;
        if (sckNow && st_q.sckPrev && st_q.sdaPrev && !sdaNow) begin
            // start, also restarts an unfinished frame
            st_d.active = 1'b1;
            st_d.bitCnt = '0;
        end else if (sckNow && st_q.sckPrev && !st_q.sdaPrev && sdaNow) begin
            // stop: only a complete frame is written
            st_d.active = 1'b0;
            // the stop's own clock rise is counted, so a complete frame ends one past
            if (st_q.active && st_q.bitCnt == 4'(laser_cfg_pkg::FRAME_BITS + 1)) begin
                st_d.req.stb  = 1'b1;
                st_d.req.addr = st_q.shift[laser_cfg_pkg::FRAME_BITS-1:laser_cfg_pkg::DATA_W];
                st_d.req.data = st_q.shift[laser_cfg_pkg::DATA_W-1:0];
            end
        end else if (st_q.active && sckNow && !st_q.sckPrev) begin
            // the rise that precedes the stop carries no bit and must not shift
            if (st_q.bitCnt < 4'(laser_cfg_pkg::FRAME_BITS)) begin
                st_d.shift = {st_q.shift[laser_cfg_pkg::FRAME_BITS-2:0], sdaNow};
            end
            // saturate beyond a complete frame so over-long frames are refused
            if (st_q.bitCnt != 4'(laser_cfg_pkg::FRAME_BITS + 2)) begin
                st_d.bitCnt = st_q.bitCnt + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q         <= '0;
            st_q.sckSync <= 2'h3;
            st_q.sdaSync <= 2'h3;
            st_q.sckPrev <= 1'b1;
            st_q.sdaPrev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign wrReq = st_q.req;

endmodule : two_wire_rx

`default_nettype wire

//--- sim/laser_driver_control_registers_tb_top.sv
// self-checking bench of the laser driver configuration bank
// assumes the host model below; drive is compared once it has settled after each action
`timescale 1ns/1ps
`default_nettype none

module laser_driver_control_registers_tb_top;

    localparam int RATIO = 40;

    logic                  mclk;
    logic                  sysRst;
    logic                  sck;
    logic                  sda;
    logic                  disablePin;
    logic                  faultDetected;
    laser_cfg_pkg::drive_s drive;
    laser_cfg_pkg::drive_s lastSeen;
    laser_cfg_pkg::drive_s lastNoted;
    laser_cfg_pkg::drive_s expQ[$];
    logic [7:0]            regs[4];
    logic                  disableM;
    logic                  faultInM;
    logic                  faultLatchM;
    logic                  pend;
    logic                  watchOn;
    int                    stable;
    int                    nErrors;
    int                    cmpCount;
    int                    cycles;
    int                    seed;

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    laser_driver_control_registers #(.COUPLING_RATIO(RATIO)) dut (
        .mclk(mclk), .sys_rst(sysRst), .sck(sck), .sda(sda),
        .disablePin(disablePin), .faultDetected(faultDetected), .drive(drive));

    serial_host_model host (.mclk(mclk), .sck(sck), .sda(sda));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic laser_cfg_pkg::drive_s expected_drive();
        laser_cfg_pkg::drive_s d;
        logic [7:0]            c;
        logic [7:0]            m;
        logic [7:0]            b;
        logic [31:0]           bi;
        c = regs[0];
        m = faultLatchM ? 8'h00 : regs[1];
        b = faultLatchM ? 8'h00 : regs[2];
        d.laserEnable      = c[7] & ~disableM & ~faultLatchM;
        d.faultOutput      = faultLatchM;
        d.monitorPolarity  = c[6];
        d.monitorRangeHigh = c[5];
        d.openLoop         = c[4];
        d.faultDetectOn    = c[3];
        d.modRangeHigh     = c[2];
        d.eqBypass         = c[1];
        d.modCode          = m;
        d.biasCode         = b;
        d.eqStrength       = c[1] ? 8'h00 : ~regs[3];
        d.modCurrentNa     = 26'(m * (c[2] ? 156000 : 78000));
        bi = c[4] ? b * 75000 : b * (c[5] ? 2500 : 500) * RATIO;
        if (!c[4] && bi > 20000000) bi = 20000000;
        d.biasCurrentNa    = bi[25:0];
        return d;
    endfunction : expected_drive

    task automatic note();
        laser_cfg_pkg::drive_s e;
        if (faultLatchM && (!regs[0][7] || disableM)) faultLatchM = 1'b0;
        if (regs[0][7] && !disableM && regs[0][3] && faultInM) faultLatchM = 1'b1;
        e = expected_drive();
        if (e !== lastNoted) begin
            expQ.push_back(e);
            lastNoted = e;
        end
    endtask : note

    task automatic check(input string what, input laser_cfg_pkg::drive_s seen,
                         input laser_cfg_pkg::drive_s exp);
        cmpCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // expectation is queued before the frame goes out, so it is always ahead of drive
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input int nbits = 11);
        if (a <= 3'h3 && nbits == 11) regs[a] = d;
        note();
        host.send({a, d}, nbits);
        repeat (12) @(posedge mclk);
    endtask : wr

    task automatic pins(input logic d, input logic f);
        disablePin    <= d;
        faultDetected <= f;
        disableM = d;
        faultInM = f;
        note();
        repeat (20) @(posedge mclk);
    endtask : pins

    task automatic tally_and_finish();
        if (nErrors == 0 && cmpCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // a change is judged only after three steady cycles, so staged updates count once
    always @(negedge mclk) begin
        if (watchOn) begin
            if (drive !== lastSeen) begin
                lastSeen = drive;
                stable   = 0;
                pend     = 1'b1;
            end else if (pend && ++stable == 3) begin
                pend = 1'b0;
                if (expQ.size() == 0) check("drive unexpected", drive, lastNoted);
                else check("drive", drive, expQ.pop_front());
            end
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            nErrors++;
            tally_and_finish();
        end
    end

    initial begin
        seed = 97235;
        sysRst = 1'b1;
        disablePin = 1'b0;
        faultDetected = 1'b0;
        {disableM, faultInM, faultLatchM, pend, watchOn} = '0;
        for (int i = 0; i < 4; i++) regs[i] = 8'h00;
        lastNoted = '0;
        repeat (5) @(posedge mclk);
        sysRst <= 1'b0;
        @(negedge mclk);
        check("reset drive", drive, '0);
        // leaving reset, drive shows the decode of the cleared registers
        note();
        lastSeen = drive;
        watchOn = 1'b1;
        repeat (4) @(posedge mclk);
        wr(3'h2, 8'($random(seed)));
        wr(3'h1, 8'($random(seed)));
        wr(3'h0, 8'h80 | 8'($random(seed) & 32'h76));
        wr(3'h3, 8'($random(seed)));
        for (int k = 0; k < 8; k++) begin
            wr(3'h2, 8'hff);
            wr(3'h0, {1'b1, k[0], k[1], k[2], 1'b0, ~k[0], k[1], 1'b0});
            wr(3'h1, 8'($random(seed)));
            wr(3'h2, 8'($random(seed)));
        end
        wr(3'h0, 8'h80);
        wr(3'h3, 8'h00);
        wr(3'h3, 8'hff);
        wr(3'h0, 8'h82);
        wr(3'h3, 8'h35);
        for (int a = 4; a < 8; a++) wr(3'(a), 8'($random(seed)));
        wr(3'h1, 8'h5a, 10);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        wr(3'h0, 8'h80);
        wr(3'h1, 8'h40);
        wr(3'h2, 8'h40);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        wr(3'h0, 8'h88);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        wr(3'h0, 8'h08);
        wr(3'h0, 8'h88);
        for (int i = 0; i < 4; i++) regs[i] = 8'h00;
        note();
        sysRst <= 1'b1;
        repeat (2) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("second reset", drive, expected_drive());
        @(posedge mclk);
        wr(3'h1, 8'hc3);
        repeat (20) @(posedge mclk);
        if (expQ.size() != 0) check("missed update", drive, expQ.pop_front());
        tally_and_finish();
    end

endmodule : laser_driver_control_registers_tb_top
`default_nettype wire

//--- sim/serial_host_model.sv
// host side of the serial write port: start, address and data MSB first, stop
// assumes the bench calls send just after a rising mclk edge; pins idle high (pull-ups)
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    // clock
    input  wire logic mclk,
    // serial pins
    output var logic  sck,
    output var logic  sda
);

    initial begin
        sck = 1'b1;
        sda = 1'b1;
    end

    // four mclk per phase: the receiver needs three for sync and edge detect
    task automatic hold();
        repeat (4) @(posedge mclk);
    endtask : hold

    // nbits below 11 sends a truncated frame that must be dropped
    task automatic send(input logic [10:0] frame, input int nbits);
        sda <= 1'b0;
        hold();
        sck <= 1'b0;
        hold();
        for (int i = 10; i > 10 - nbits; i--) begin
            sda <= frame[i];
            hold();
            sck <= 1'b1;
            hold();
            sck <= 1'b0;
            hold();
        end
        sda <= 1'b0;
        hold();
        sck <= 1'b1;
        hold();
        sda <= 1'b1;
        hold();
    endtask : send

endmodule : serial_host_model
`default_nettype wire
